// [rtl/ssr_top.sv]
// Read port, address capture and write capture of a DDR burst-of-two synchronous SRAM
`timescale 1ns/1ps

// ************************************************************
// Burst FIFO
// ************************************************************
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push, pop;

  assign o_in_ready = (count_reg != DEPTH[PW:0]);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ************************************************************
// Top
// ************************************************************
module ssr_top
  import ssr_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Pin clocks, sampled
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_single_clock,
  // Command and address pins
  input wire logic i_read_port_select_n,
  input wire logic i_write_port_select_n,
  input wire logic [ADDR_W-1:0] i_addr,
  // Write data pins
  input wire logic [DATA_W-1:0] i_d,
  input wire logic [NUM_BYTES-1:0] i_byte_write_mask_n,
  // Read data pins
  output logic [DATA_W-1:0] o_q,
  output logic o_q_oe,
  output logic o_read_dropped
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int SYNC_W = 7 + ADDR_W + DATA_W + NUM_BYTES;
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic [3:0] clk_d_reg;
  logic k_s, kn_s, c_s, cn_s, single_s;
  logic rsel_n_s, wsel_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;
  logic [NUM_BYTES-1:0] mask_n_s;
  logic k_rise, kn_rise, out_pos_rise, out_neg_rise;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      clk_d_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= {i_k, i_k_n, i_c, i_c_n, i_single_clock, i_read_port_select_n,
                   i_write_port_select_n, i_addr, i_d, i_byte_write_mask_n};
      sync_reg <= meta_reg;
      clk_d_reg <= {k_s, kn_s, c_s, cn_s};
    end
  end

  assign {k_s, kn_s, c_s, cn_s, single_s, rsel_n_s, wsel_n_s, addr_s, d_s, mask_n_s} = sync_reg;
  assign k_rise = k_s && !clk_d_reg[3];
  assign kn_rise = kn_s && !clk_d_reg[2];
  assign out_pos_rise = single_s ? k_rise : (c_s && !clk_d_reg[1]);
  assign out_neg_rise = single_s ? kn_rise : (cn_s && !clk_d_reg[0]);

  // ************************************************************
  // Memory array
  // ************************************************************
  // Two words per location
  logic [DATA_W-1:0] lo_mem [DEPTH_WORDS];
  logic [DATA_W-1:0] hi_mem [DEPTH_WORDS];

  // ************************************************************
  // Write port
  // ************************************************************
  logic wr_pend_reg;
  logic [DATA_W-1:0] wr_d0_reg;
  logic [NUM_BYTES-1:0] wr_m0_reg;

  // Write begins on K with select low
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_d0_reg <= Q_RESET;
      wr_m0_reg <= MASK_NONE;
    end
    else if (k_rise)
    begin
      wr_pend_reg <= !wsel_n_s;
      wr_d0_reg <= d_s;
      wr_m0_reg <= mask_n_s;
    end
    else if (kn_rise)
    begin
      wr_pend_reg <= 1'b0;
    end
  end

  // Write address and second beat on K-bar
  always_ff @(posedge i_clock)
  begin
    if (kn_rise && wr_pend_reg)
    begin
      for (int b = 0; b < NUM_BYTES; b++)
      begin
        if (!wr_m0_reg[b])
        begin
          lo_mem[addr_s][b*BYTE_W +: BYTE_W] <= wr_d0_reg[b*BYTE_W +: BYTE_W];
        end
        if (!mask_n_s[b])
        begin
          hi_mem[addr_s][b*BYTE_W +: BYTE_W] <= d_s[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ************************************************************
  // Read request capture
  // ************************************************************
  logic stage_valid_reg;
  logic [BURST_W-1:0] stage_data_reg;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [BURST_W-1:0] fifo_out_data;

  // Burst waits a full input cycle in the stage, so it leaves on the next K
  assign fifo_in_valid = k_rise && stage_valid_reg;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stage_valid_reg <= 1'b0;
    end
    else if (k_rise)
    begin
      stage_valid_reg <= !rsel_n_s;
    end
  end

  // Read address taken on K only
  always_ff @(posedge i_clock)
  begin
    if (k_rise && !rsel_n_s)
    begin
      stage_data_reg <= {hi_mem[addr_s], lo_mem[addr_s]};
    end
  end

  // A full FIFO means the controller overran the read port; the request is lost
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_read_dropped <= 1'b0;
    end
    else
    begin
      o_read_dropped <= fifo_in_valid && !fifo_in_ready;
    end
  end

  ssr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(stage_data_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // ************************************************************
  // Output launch
  // ************************************************************
  ssr_out_state_t state_reg;
  logic [DATA_W-1:0] word1_reg;

  // Pop only on an output edge after the staging cycle
  assign fifo_out_ready = out_pos_rise && (state_reg == SSR_OUT_IDLE);

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= SSR_OUT_IDLE;
      o_q <= Q_RESET;
      o_q_oe <= 1'b0;
      word1_reg <= Q_RESET;
    end
    else
    begin
      case (state_reg)
        SSR_OUT_IDLE:
        begin
          if (out_pos_rise)
          begin
            if (fifo_out_valid)
            begin
              o_q <= fifo_out_data[DATA_W-1:0];
              o_q_oe <= 1'b1;
              word1_reg <= fifo_out_data[BURST_W-1:DATA_W];
              state_reg <= SSR_OUT_SECOND;
            end
            else
            begin
              // Release on this output rise (C, or K in single clock mode)
              o_q_oe <= 1'b0;
            end
          end
        end
        SSR_OUT_SECOND:
        begin
          if (out_neg_rise)
          begin
            o_q <= word1_reg;
            state_reg <= SSR_OUT_IDLE;
          end
        end
        default:
        begin
          state_reg <= SSR_OUT_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_read_req;
    k_rise && !rsel_n_s;
  endsequence
  sequence s_first_launch;
    out_pos_rise && fifo_out_valid && state_reg == SSR_OUT_IDLE;
  endsequence
  a_read_capture: assert property (s_read_req |=> stage_valid_reg)
    else $error("read request not staged");
  a_deselect_ignored: assert property (k_rise && rsel_n_s |=> !stage_valid_reg)
    else $error("deselected read was staged");
  a_stage_push: assert property (fifo_in_valid && fifo_in_ready |=> fifo_out_valid)
    else $error("staged burst not queued on K");
  a_launch_edge: assert property ($rose(o_q_oe) |-> $past(out_pos_rise))
    else $error("output enabled off a positive output edge");
  a_first_word: assert property (s_first_launch |=> o_q_oe && state_reg == SSR_OUT_SECOND)
    else $error("first word not launched");
  a_second_word: assert property (state_reg == SSR_OUT_SECOND && out_neg_rise
      |=> o_q == $past(word1_reg) && o_q_oe)
    else $error("second word wrong");
  a_release_idle: assert property (out_pos_rise && !fifo_out_valid
      && state_reg == SSR_OUT_IDLE |=> !o_q_oe)
    else $error("outputs not released when idle");
  a_single_edge: assert property (single_s && $rose(o_q_oe) |-> $past(k_rise))
    else $error("single clock launch not on K");
  a_write_once: assert property (kn_rise && wr_pend_reg |=> !wr_pend_reg)
    else $error("write pending past K-bar");

endmodule

// [shared/ssr_pkg.sv]
// Shared constants for the synchronous SRAM read port block
package ssr_pkg;

  // Organisation: x36, two words per location
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 4;
  localparam int BURST_W = 2 * DATA_W;
  localparam int DEPTH_WORDS = 1 << ADDR_W;

  // Burst FIFO
  localparam int FIFO_WIDTH = BURST_W;
  localparam int FIFO_DEPTH = 8;

  // Read latency in input half cycles with the PLL enabled
  localparam int READ_LATENCY_HALF = 3;

  // Reset values
  localparam logic [DATA_W-1:0] Q_RESET = 36'h0_0000_0000;
  localparam logic [NUM_BYTES-1:0] MASK_NONE = 4'hF;

  typedef enum {SSR_OUT_IDLE, SSR_OUT_SECOND} ssr_out_state_t;

endpackage

// [verification/ssr_ctrl_model.sv]
// Controller model driving the input and output clock pairs
`timescale 1ns/1ps

// ********
// Clocks
// ********
module ssr_ctrl_model #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Output clock stall
  input wire logic i_c_stall,
  // Pin clocks
  output logic o_k,
  output logic o_k_n,
  output logic o_c,
  output logic o_c_n
);
  int k_cnt_reg;
  int c_cnt_reg;
  logic k_run_reg;
  logic c_run_reg;
  always_ff @(negedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      k_cnt_reg <= 0;
      k_run_reg <= 1'b0;
    end
    else
    begin
      k_cnt_reg <= (k_cnt_reg + 1) % (2 * HALF);
      k_run_reg <= k_run_reg | (k_cnt_reg == HALF - 1);
    end
  end
  always_ff @(negedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      c_cnt_reg <= 3;
      c_run_reg <= 1'b0;
    end
    else if (!i_c_stall)
    begin
      c_cnt_reg <= (c_cnt_reg + 1) % (2 * HALF);
      c_run_reg <= c_run_reg | (c_cnt_reg == HALF - 1);
    end
  end
  // Negative clocks stay low until their positive twin first rises
  assign o_k = k_cnt_reg >= HALF;
  assign o_k_n = k_run_reg && k_cnt_reg < HALF;
  assign o_c = c_cnt_reg >= HALF;
  assign o_c_n = c_run_reg && c_cnt_reg < HALF;
endmodule

// [verification/test_ssr_top.sv]
// Self-checking bench for the synchronous SRAM read port
`timescale 1ns/1ps
module test_ssr_top;
  import ssr_pkg::*;
  typedef logic [BURST_W-1:0] ssr_burst_t;
  localparam ssr_burst_t P0 = 72'hA5_0123_4567_89AB_CDEF;
  localparam ssr_burst_t P1 = 72'h5A_FEDC_BA98_7654_3210;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic k, k_n, c, c_n;
  logic c_stall = 1'b0;
  logic single_clock = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] d = '0;
  logic [NUM_BYTES-1:0] mask_n = MASK_NONE;
  logic [DATA_W-1:0] q;
  logic q_oe, dropped;
  int fail_count = 0;
  int n_tests = 0;
  int drops = 0;
  ssr_burst_t exp_q[$];
  always #2.5 clock = ~clock;
  always @(negedge clock) if (dropped === 1'b1) drops++;
  ssr_ctrl_model i_ssr_ctrl_model (.i_clock(clock), .i_sys_rst(sys_rst), .i_c_stall(c_stall),
    .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n));
  ssr_top i_ssr_top (.i_clock(clock), .i_sys_rst(sys_rst), .i_k(k), .i_k_n(k_n), .i_c(c),
    .i_c_n(c_n), .i_single_clock(single_clock), .i_read_port_select_n(rd_n),
    .i_write_port_select_n(wr_n), .i_addr(addr), .i_d(d), .i_byte_write_mask_n(mask_n),
    .o_q(q), .o_q_oe(q_oe), .o_read_dropped(dropped));

  // ********
  // Helpers
  // ********
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic ssr_burst_t merge(input ssr_burst_t old, input ssr_burst_t nw,
                                       input logic [7:0] m);
    ssr_burst_t r;
    r = old;
    for (int b = 0; b < 8; b++)
      if (!m[b])
        r[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
    return r;
  endfunction
  // Pins are moved mid half period, well clear of the synchronisers
  task automatic k_cycle(input logic r, input logic w, input logic [ADDR_W-1:0] ra,
                         input logic [ADDR_W-1:0] wa, input ssr_burst_t wd, input logic [7:0] m);
    @(posedge k_n);
    repeat (4) @(negedge clock);
    rd_n = r;
    wr_n = w;
    addr = ra;
    d = wd[DATA_W-1:0];
    mask_n = m[3:0];
    @(posedge k);
    repeat (4) @(negedge clock);
    addr = wa;
    d = wd[BURST_W-1:DATA_W];
    mask_n = m[7:4];
  endtask
  task automatic launch(input logic second);
    if (second)
      @(posedge (single_clock ? k_n : c_n));
    else
      @(posedge (single_clock ? k : c));
    repeat (5) @(negedge clock);
  endtask
  task automatic drain();
    int i;
    i = 0;
    while (q_oe !== 1'b1 && i < 500)
    begin
      @(negedge clock);
      i++;
    end
    foreach (exp_q[j])
    begin
      if (j > 0)
        launch(1'b0);
      check(q, exp_q[j][DATA_W-1:0]);
      launch(1'b1);
      check(q, exp_q[j][BURST_W-1:DATA_W]);
    end
    launch(1'b0);
    check(DATA_W'(q_oe), '0);
    exp_q = {};
  endtask
  task automatic reads(input logic [ADDR_W-1:0] a0, input logic [ADDR_W-1:0] a1);
    fork
      begin
        k_cycle(1'b0, 1'b1, a0, '0, '0, 8'hFF);
        k_cycle(1'b0, 1'b1, a1, '0, '0, 8'hFF);
        k_cycle(1'b1, 1'b1, a1, '0, '0, 8'hFF);
      end
      drain();
    join
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_basic();
    k_cycle(1'b1, 1'b0, '0, '0, P0, 8'h00);
    k_cycle(1'b1, 1'b0, '0, 19'h7FFFF, P1, 8'h00);
    k_cycle(1'b1, 1'b0, '0, '0, P1, 8'h5A);
    k_cycle(1'b1, 1'b1, '0, 19'h7FFFF, P0, 8'h00);
    k_cycle(1'b1, 1'b1, '0, '0, '0, 8'hFF);
    exp_q = {merge(P0, P1, 8'h5A), P1};
    reads('0, 19'h7FFFF);
  endtask
  // Output clocks held still so the burst buffer fills and refuses
  task automatic t_fifo();
    int base;
    base = drops;
    c_stall <= 1'b1;
    repeat (FIFO_DEPTH + 2)
      k_cycle(1'b0, 1'b1, 19'h7FFFF, '0, '0, 8'hFF);
    repeat (2)
      k_cycle(1'b1, 1'b1, '0, '0, '0, 8'hFF);
    check(DATA_W'(drops - base), 36'h2);
    repeat (FIFO_DEPTH)
      exp_q.push_back(P1);
    c_stall <= 1'b0;
    drain();
  endtask
  task automatic t_single();
    single_clock <= 1'b1;
    exp_q = {P1, merge(P0, P1, 8'h5A)};
    reads(19'h7FFFF, '0);
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_basic();
    t_fifo();
    t_single();
    conclude();
  end
  initial
  begin
    #100000;
    fail_count++;
    $display("mismatch at %0t: timeout", $time);
    conclude();
  end
endmodule
